// file: rtl/actuator_can_message_framer.sv
// actuator message framer: command check and decode, data and diagnostics frames
// assumes a CAN controller that hands over whole frames and takes frames on
// tx_valid/tx_ready; registers over APB, inputs synchronous to pclk
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module actuator_can_message_framer
  import framer_pkg::*;
#(
  parameter int TICK_CYC = MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic addr_select_high_input,
  input wire logic addr_select_low_input,
  input wire logic rx_valid,
  input wire can_frame_t rx_frame,
  input wire diag_in_t diag,
  input wire logic [7:0] actual_pos,
  input wire logic name_changed,
  output can_frame_t tx_frame,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [31:0] demand_pos,
  output logic demand_fault,
  output logic [7:0] source_addr,
  output logic [1:0] primary_bitrate,
  output logic [1:0] service_bitrate
);
  localparam int TW = $clog2(TICK_CYC + 1);

  function automatic logic [1:0] cd(input logic act);
    cd = act ? CD_ACT : CD_INACT;
  endfunction

  function automatic logic [7:0] pos_byte(input logic [31:0] d);
    logic [48:0] p;
    p = 49'(d - DEM_LO) * 49'(POS_K);
    pos_byte = p[47:40];
  endfunction

  logic [5:0] ctrl_r;
  logic [7:0] src_r;
  logic [15:0] tmo_r;
  logic [1:0] unit_r;
  logic unit_ok_r;
  logic [TW-1:0] tick_cnt_r;
  logic tick_r;
  logic [15:0] age_r;
  logic inval_r;
  logic claim_fail_r;
  logic [9:0] data_ms_r;
  logic [9:0] diag_ms_r;
  logic data_pend_r;
  logic diag_pend_r;
  logic [31:0] code;
  logic [31:0] clamped;
  logic cmd_hit;
  logic active;
  logic bus_fail;
  logic int_fault;
  logic load_data;
  logic load_diag;
  logic [9:0] diag_period;
  logic [63:0] diag_data;
  usage_t usage;
  compat_t mode;

  assign usage = usage_t'(ctrl_r[CTRL_USE +: 2]);
  assign mode = compat_t'(ctrl_r[CTRL_MODE +: 2]);
  assign active = (usage == USE_MON || usage == USE_CTL) && mode != MODE_B;
  assign bus_fail = demand_fault;
  assign int_fault = diag.nv_fail | diag.volt_fault | diag.wdog_reset
    | diag.pos_sens_fail;

  // command acceptance: extended, page 0, this unit's group only
  assign cmd_hit = rx_valid && rx_frame.ide && active
    && rx_frame.id[25:8] == CMD_PGN_BASE + 18'(unit_r);
  assign code = {rx_frame.data[31:24], rx_frame.data[23:16],
    rx_frame.data[15:8], rx_frame.data[7:0]};
  assign clamped = code < DEM_LO ? DEM_LO
    : (code > DEM_HI ? DEM_HI : code);

  // apb register port, one access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (ce)
    begin
      pready <= psel & ~penable;
      if (psel && !penable)
      begin
        pslverr <= 1'b0;
        unique case (paddr)
          A_CTRL: prdata <= {26'h0, ctrl_r};
          A_SRC: prdata <= {24'h0, src_r};
          A_TMO: prdata <= {16'h0, tmo_r};
          A_STAT: prdata <= {13'h0, inval_r, claim_fail_r, demand_fault,
            source_addr, 6'h0, unit_r};
          A_DEM: prdata <= demand_pos;
          default:
          begin
            prdata <= 32'h00000000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_r <= CTRL_RST;
      src_r <= SRC_RST;
      tmo_r <= TMO_RST;
    end
    else if (ce && psel && penable && pready && pwrite)
    begin
      if (paddr == A_CTRL)
        ctrl_r <= pwdata[5:0];
      if (paddr == A_SRC)
        src_r <= pwdata[7:0];
      if (paddr == A_TMO)
        tmo_r <= pwdata[15:0];
    end
  end

  // bus rates
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      primary_bitrate <= RATE_250K;
      service_bitrate <= RATE_1M;
    end
    else if (ce)
    begin
      primary_bitrate <= ctrl_r[CTRL_RATE +: 2];
      service_bitrate <= RATE_1M;
    end
  end

  // unit number caught once after reset release
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unit_r <= 2'b00;
      unit_ok_r <= 1'b0;
    end
    else if (ce && !unit_ok_r)
    begin
      unit_r <= {addr_select_high_input, addr_select_low_input};
      unit_ok_r <= 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      source_addr <= SA_BASE;
    else if (ce)
      source_addr <= mode == MODE_B ? src_r : SA_BASE + 8'(unit_r);
  end

  // millisecond tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tick_cnt_r <= '0;
      tick_r <= 1'b0;
    end
    else if (ce)
    begin
      tick_r <= tick_cnt_r == TW'(TICK_CYC - 1);
      tick_cnt_r <= tick_cnt_r == TW'(TICK_CYC - 1) ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // demand supervision
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      age_r <= 16'h0000;
      inval_r <= 1'b0;
      demand_fault <= 1'b0;
    end
    else if (ce)
    begin
      if (usage != USE_CTL)
      begin
        age_r <= 16'h0000;
        inval_r <= 1'b0;
        demand_fault <= 1'b0;
      end
      else
      begin
        if (cmd_hit)
        begin
          age_r <= 16'h0000;
          inval_r <= rx_frame.dlc != CMD_DLC;
        end
        else if (tick_r && age_r != 16'hffff)
          age_r <= age_r + 16'h0001;
        demand_fault <= inval_r || age_r > tmo_r;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      claim_fail_r <= 1'b0;
    else if (ce)
    begin
      if (diag.address_claim_fail_fault)
        claim_fail_r <= 1'b1;
      else if (name_changed)
        claim_fail_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      demand_pos <= DEM_LO;
    else if (ce)
    begin
      if (claim_fail_r)
        demand_pos <= DEM_LO;
      else if (cmd_hit && usage == USE_CTL && rx_frame.dlc == CMD_DLC
          && !diag.bus_error_passive_fault)
        demand_pos <= clamped;
    end
  end

  // transmit schedule
  assign diag_period = (mode == MODE_A || mode == MODE_C)
    ? 10'(DIAG_FAST_MS) : 10'(DIAG_SLOW_MS);
  assign load_data = data_pend_r && !tx_valid;
  assign load_diag = diag_pend_r && !data_pend_r && !tx_valid;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_ms_r <= 10'h000;
      diag_ms_r <= 10'h000;
      data_pend_r <= 1'b0;
      diag_pend_r <= 1'b0;
    end
    else if (ce)
    begin
      if (!active)
      begin
        data_ms_r <= 10'h000;
        diag_ms_r <= 10'h000;
        data_pend_r <= 1'b0;
        diag_pend_r <= 1'b0;
      end
      else
      begin
        if (tick_r)
        begin
          data_ms_r <= data_ms_r >= 10'(DATA_PERIOD_MS - 1) ? 10'h000
            : data_ms_r + 10'h001;
          diag_ms_r <= diag_ms_r >= diag_period - 10'h001 ? 10'h000
            : diag_ms_r + 10'h001;
        end
        data_pend_r <= (tick_r && data_ms_r >= 10'(DATA_PERIOD_MS - 1))
          || (data_pend_r && !load_data);
        diag_pend_r <= (tick_r && diag_ms_r >= diag_period - 10'h001)
          || (diag_pend_r && !load_diag);
      end
    end
  end

  // diagnostics payload, byte 1 in the low bits, bit pair n at n-1
  always_comb
  begin
    diag_data = {8{BYTE_NA}};
    unique case (mode)
      MODE_A:
      begin
        diag_data[7:0] = {CD_INACT, cd(int_fault), cd(bus_fail),
          cd(diag.stop_cmd)};
        diag_data[15:8] = {cd(diag.gen_shutdown), cd(diag.gen_alarm),
          CD_INACT, CD_INACT};
        diag_data[39:32] = {cd(diag.supply_high), CD_INACT,
          cd(diag.temp_high | diag.temp_sens_fail), cd(diag.pos_error)};
        diag_data[47:40] = {CD_NA, cd(diag.powerup_reset), CD_INACT,
          cd(diag.supply_low)};
      end
      MODE_C:
      begin
        diag_data[7:0] = {cd(diag.analog_dem_fail), cd(int_fault),
          cd(bus_fail), cd(diag.stop_cmd)};
        diag_data[15:8] = {cd(diag.gen_shutdown), cd(diag.gen_alarm),
          CD_NA, cd(diag.pwm_dem_fail)};
        diag_data[39:32] = {cd(diag.supply_high | diag.supply_low), CD_NA,
          cd(diag.temp_sens_fail), cd(diag.pos_error)};
        diag_data[47:40] = {cd(diag.derate_100c), cd(diag.powerup_reset),
          cd(diag.temp_sens_fail), cd(diag.supply_high | diag.supply_low)};
        diag_data[55:48] = {CD_NA, CD_NA, CD_NA,
          cd(diag.zero_torque_140c)};
      end
      MODE_D:
      begin
        diag_data[7:0] = {cd(diag.nv_fail | diag.temp_sens_fail
          | diag.volt_fault | diag.wdog_reset),
          cd(diag.pos_sens_fail | diag.wdog_reset), cd(bus_fail),
          cd(diag.stop_cmd)};
        diag_data[15:8] = {CD_NA, CD_NA, cd(diag.pwm_dem_fail),
          cd(diag.analog_dem_fail)};
        diag_data[39:32] = {cd(diag.supply_high), cd(diag.derate_100c),
          cd(diag.temp_high), cd(diag.pos_error)};
        diag_data[47:40] = {CD_NA, CD_NA, CD_NA, cd(diag.supply_low)};
      end
      MODE_B:
        diag_data = {8{BYTE_NA}};
    endcase
  end

  // frame output, held until taken
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_valid <= 1'b0;
      tx_frame <= '0;
    end
    else if (ce)
    begin
      if (tx_valid && tx_ready)
        tx_valid <= 1'b0;
      else if (load_data)
      begin
        tx_valid <= 1'b1;
        tx_frame.ide <= 1'b1;
        tx_frame.id <= {DATA_PRIO, DATA_PGN, source_addr};
        tx_frame.dlc <= TX_DLC;
        tx_frame.data <= {{6{BYTE_NA}}, pos_byte(demand_pos),
          actual_pos};
      end
      else if (load_diag)
      begin
        tx_valid <= 1'b1;
        tx_frame.ide <= 1'b1;
        tx_frame.id <= {DIAG_PRIO, DIAG_PGN, source_addr};
        tx_frame.dlc <= TX_DLC;
        tx_frame.data <= diag_data;
      end
    end
  end
endmodule // actuator_can_message_framer
`default_nettype wire

// file: rtl/framer_pkg.sv
// constants, modes and frame carriers for the actuator message framer
// assumes a 25 MHz controller clock and a CAN controller outside
package framer_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SRC = 8'h04;
  localparam logic [7:0] A_TMO = 8'h08;
  localparam logic [7:0] A_STAT = 8'h0c;
  localparam logic [7:0] A_DEM = 8'h10;
  typedef enum logic [1:0] {USE_OFF = 2'b00, USE_MON = 2'b01, USE_CTL = 2'b10} usage_t;
  typedef enum logic [1:0] {
    MODE_A = 2'b00, MODE_B = 2'b01, MODE_C = 2'b10, MODE_D = 2'b11
  } compat_t;
  typedef enum logic [1:0] {
    RATE_125K = 2'b00, RATE_250K = 2'b01, RATE_500K = 2'b10, RATE_1M = 2'b11
  } rate_t;
  // ctrl fields: [1:0] usage, [3:2] compat mode, [5:4] primary rate
  localparam int CTRL_USE = 0;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_RATE = 4;
  localparam logic [5:0] CTRL_RST = 6'h10;
  localparam logic [7:0] SRC_RST = 8'h00;
  localparam logic [15:0] TMO_RST = 16'h0064;
  // status fields
  localparam int ST_UNIT = 0;
  localparam int ST_SA = 8;
  localparam int ST_DFLT = 16;
  localparam int ST_CLAIM = 17;
  localparam int ST_INVAL = 18;
  // message layout
  localparam logic [7:0] SA_BASE = 8'h13;
  localparam logic [17:0] CMD_PGN_BASE = 18'h0ff16;
  localparam logic [17:0] DATA_PGN = 18'h0fffb;
  localparam logic [17:0] DIAG_PGN = 18'h0ff10;
  localparam logic [2:0] DATA_PRIO = 3'h7;
  localparam logic [2:0] DIAG_PRIO = 3'h6;
  localparam logic [3:0] CMD_DLC = 4'h4;
  localparam logic [3:0] TX_DLC = 4'h8;
  localparam logic [7:0] BYTE_NA = 8'hff;
  localparam logic [1:0] CD_INACT = 2'b00;
  localparam logic [1:0] CD_ACT = 2'b01;
  localparam logic [1:0] CD_NA = 2'b11;
  // demand codes at 0 % and 100 %, and byte scale factor (>> 40)
  localparam logic [31:0] DEM_LO = 32'h0ba2e8ba;
  localparam logic [31:0] DEM_HI = 32'hf45d1746;
  localparam logic [16:0] POS_K = 17'h11881;
  // timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int DATA_PERIOD_MS = 100;
  localparam int DIAG_FAST_MS = 100;
  localparam int DIAG_SLOW_MS = 1000;
  typedef struct packed {
    logic ide;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } can_frame_t;
  typedef struct packed {
    logic stop_cmd;
    logic nv_fail;
    logic volt_fault;
    logic wdog_reset;
    logic pos_sens_fail;
    logic temp_high;
    logic temp_sens_fail;
    logic pos_error;
    logic supply_high;
    logic supply_low;
    logic powerup_reset;
    logic gen_alarm;
    logic gen_shutdown;
    logic analog_dem_fail;
    logic pwm_dem_fail;
    logic derate_100c;
    logic zero_torque_140c;
    logic address_claim_fail_fault;
    logic bus_error_passive_fault;
  } diag_in_t;
endpackage

// file: sim/actuator_can_message_framer_tb_top.sv
// self-checking bench for the actuator message framer
// assumes ecu_model on the far side and a 10-cycle millisecond tick
`timescale 1ns/1ps
`default_nettype none
module actuator_can_message_framer_tb_top;
  import framer_pkg::*;
  localparam int TICK = 10;
  logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0, actual_pos, source_addr;
  logic [31:0] pwdata = '0, prdata, demand_pos, dem, code;
  logic pready, pslverr, rx_valid, tx_valid, tx_ready, demand_fault;
  logic addr_select_high_input = 1, addr_select_low_input = 0, name_changed = 0;
  logic [1:0] primary_bitrate, service_bitrate;
  can_frame_t rx_frame, tx_frame;
  diag_in_t diag = '0;
  logic [32:0] rq[$];
  can_frame_t tq[$];
  int errors = 0, samples_checked = 0, cyc = 0, txn = 0, seed = 1646;
  always #20 pclk = ~pclk;
  actuator_can_message_framer #(.TICK_CYC(TICK)) dut (.pclk(pclk), .presetn(presetn),
    .ce(ce), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .addr_select_high_input(addr_select_high_input),
    .addr_select_low_input(addr_select_low_input), .rx_valid(rx_valid),
    .rx_frame(rx_frame), .diag(diag), .actual_pos(actual_pos), .name_changed(name_changed),
    .tx_frame(tx_frame), .tx_valid(tx_valid), .tx_ready(tx_ready), .demand_pos(demand_pos),
    .demand_fault(demand_fault), .source_addr(source_addr),
    .primary_bitrate(primary_bitrate), .service_bitrate(service_bitrate));
  ecu_model ecu (.pclk(pclk), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_frame(rx_frame));
  task automatic chk(input string nm, input logic [97:0] s, input logic [97:0] e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic tally_and_finish();
    if (errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
    input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    if (!w)
      rq.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic can_frame_t frm(input logic [2:0] p, input logic [17:0] g,
    input logic [63:0] d);
    return {1'b1, p, g, 8'h15, TX_DLC, d};
  endfunction
  function automatic logic [7:0] dbyte(input logic [31:0] v);
    logic [63:0] t;
    t = 64'(v - DEM_LO) * 64'(POS_K);
    return t[47:40];
  endfunction
  function automatic logic [1:0] c2(input logic a);
    return a ? CD_ACT : CD_INACT;
  endfunction
  // expected diagnostics payload: d=0 mode c, d=1 mode d; f is the bus demand fault
  function automatic logic [63:0] dexp(input logic d, input diag_in_t g, input logic f);
    logic i;
    i = g.nv_fail | g.volt_fault | g.wdog_reset | g.pos_sens_fail;
    if (d)
      return {16'hffff, 6'h3f, c2(g.supply_low), c2(g.supply_high), c2(g.derate_100c),
        c2(g.temp_high), c2(g.pos_error), 16'hffff, 4'hf, c2(g.pwm_dem_fail),
        c2(g.analog_dem_fail), c2(g.nv_fail | g.temp_sens_fail | g.volt_fault | g.wdog_reset),
        c2(g.pos_sens_fail | g.wdog_reset), c2(f), c2(g.stop_cmd)};
    else
      return {8'hff, 6'h3f, c2(g.zero_torque_140c), c2(g.derate_100c), c2(g.powerup_reset),
        c2(g.temp_sens_fail), c2(g.supply_high | g.supply_low),
        c2(g.supply_high | g.supply_low), CD_NA, c2(g.temp_sens_fail), c2(g.pos_error),
        16'hffff, c2(g.gen_shutdown), c2(g.gen_alarm), CD_NA, c2(g.pwm_dem_fail),
        c2(g.analog_dem_fail), c2(i), c2(f), c2(g.stop_cmd)};
  endfunction
  // result watcher: takes the oldest note when a result shows
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite && rq.size() > 0)
      chk("apb_read", 98'({pslverr, prdata}), 98'(rq.pop_front()));
    if (tx_valid && tx_ready)
    begin
      txn <= txn + 1;
      if (tq.size() > 0)
        chk("tx_frame", tx_frame, tq.pop_front());
    end
    if (cyc == 20000)
    begin
      errors++;
      tally_and_finish();
    end
  end
  initial
  begin
    actual_pos = 8'($random(seed));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    addr_select_high_input <= 1'b0;
    addr_select_low_input <= 1'b1;
    apb(A_CTRL, 0, 0, 33'h10);
    apb(A_SRC, 0, 0, 33'h0);
    apb(A_TMO, 0, 0, 33'h64);
    apb(A_STAT, 0, 0, 33'h1502);
    apb(8'h14, 0, 0, {1'b1, 32'h0});
    @(negedge pclk);
    chk("src_addr", 98'(source_addr), 98'h15);
    chk("svc_rate", 98'(service_bitrate), 98'h3);
    for (int r = 0; r < 4; r++)
    begin
      apb(A_CTRL, 1, 32'(r << 4), 0);
      repeat (2) @(negedge pclk);
      chk("rate", 98'(primary_bitrate), 98'(r));
    end
    apb(A_TMO, 1, 32'hffff, 0);
    apb(A_CTRL, 1, 32'h12, 0);
    for (int i = 0; i < 3; i++)
    begin
      code = (i == 0) ? 32'h0 : (i == 1) ? 32'hffffffff : $random(seed);
      dem = (code < DEM_LO) ? DEM_LO : (code > DEM_HI) ? DEM_HI : code;
      ecu.send_cmd(2'd2, code, CMD_DLC);
      @(negedge pclk);
      chk("demand", 98'(demand_pos), 98'(dem));
    end
    ecu.send_cmd(2'd0, 32'h80000000, CMD_DLC);
    @(negedge pclk);
    chk("demand_other", 98'(demand_pos), 98'(dem));
    tq.push_back(frm(DATA_PRIO, DATA_PGN, {48'hffffffffffff, dbyte(dem), actual_pos}));
    tq.push_back(frm(DIAG_PRIO, DIAG_PGN, 64'hffffc000ffff0000));
    wait (txn == 2);
    apb(A_TMO, 1, 32'h2, 0);
    ecu.send_cmd(2'd2, dem, CMD_DLC);
    repeat (2) @(negedge pclk);
    chk("fault_clear", 98'(demand_fault), 98'h0);
    repeat (5 * TICK) @(negedge pclk);
    chk("fault_late", 98'(demand_fault), 98'h1);
    tq.push_back(frm(DATA_PRIO, DATA_PGN, {48'hffffffffffff, dbyte(dem), actual_pos}));
    tq.push_back(frm(DIAG_PRIO, DIAG_PGN, 64'hffffc000ffff0004));
    wait (txn == 4);
    ecu.send_cmd(2'd2, dem, CMD_DLC);
    ecu.send_cmd(2'd2, 32'h0, 4'h3);
    repeat (2) @(negedge pclk);
    chk("fault_inval", 98'(demand_fault), 98'h1);
    chk("demand_kept", 98'(demand_pos), 98'(dem));
    apb(A_STAT, 0, 0, 33'h51502);
    diag <= diag_in_t'(19'($random(seed)) & 19'h7fffc);
    apb(A_CTRL, 1, 32'h1a, 0);
    tq.push_back(frm(DATA_PRIO, DATA_PGN, {48'hffffffffffff, dbyte(dem), actual_pos}));
    tq.push_back(frm(DIAG_PRIO, DIAG_PGN, dexp(1'b0, diag, 1'b1)));
    wait (txn == 6);
    apb(A_CTRL, 1, 32'h1e, 0);
    repeat (10)
      tq.push_back(frm(DATA_PRIO, DATA_PGN, {48'hffffffffffff, dbyte(dem), actual_pos}));
    tq.push_back(frm(DIAG_PRIO, DIAG_PGN, dexp(1'b1, diag, 1'b1)));
    wait (txn == 17);
    @(posedge pclk);
    diag <= diag_in_t'(19'h00001);
    ecu.send_cmd(2'd2, 32'h80000000, CMD_DLC);
    @(negedge pclk);
    chk("demand_frozen", 98'(demand_pos), 98'(dem));
    @(posedge pclk);
    diag <= diag_in_t'(19'h00000);
    ecu.send_cmd(2'd2, 32'h80000000, CMD_DLC);
    @(negedge pclk);
    chk("demand_mid", 98'(demand_pos), 98'h80000000);
    @(posedge pclk);
    diag <= diag_in_t'(19'h00002);
    ecu.send_cmd(2'd2, 32'h90000000, CMD_DLC);
    @(negedge pclk);
    chk("demand_claim", 98'(demand_pos), 98'(DEM_LO));
    @(posedge pclk);
    diag <= diag_in_t'(19'h00000);
    name_changed <= 1'b1;
    @(posedge pclk);
    name_changed <= 1'b0;
    ecu.send_cmd(2'd2, 32'h90000000, CMD_DLC);
    @(negedge pclk);
    chk("demand_retry", 98'(demand_pos), 98'h90000000);
    @(posedge pclk);
    ce <= 1'b0;
    ecu.send_cmd(2'd2, 32'h30000000, CMD_DLC);
    @(posedge pclk);
    ce <= 1'b1;
    @(negedge pclk);
    chk("demand_ce_low", 98'(demand_pos), 98'h90000000);
    apb(A_CTRL, 1, 32'h11, 0);
    ecu.send_cmd(2'd2, 32'h30000000, CMD_DLC);
    @(negedge pclk);
    chk("demand_monitor", 98'(demand_pos), 98'h90000000);
    chk("fault_monitor", 98'(demand_fault), 98'h0);
    apb(A_SRC, 1, 32'h5a, 0);
    apb(A_CTRL, 1, 32'h16, 0);
    repeat (2) @(negedge pclk);
    chk("src_user", 98'(source_addr), 98'h5a);
    tally_and_finish();
  end
endmodule // actuator_can_message_framer_tb_top
`default_nettype wire

// file: sim/ecu_model.sv
// engine control unit model: sends command frames, takes frames with stalls
// assumes the framer's pclk and tx_valid/tx_ready handshake
`timescale 1ns/1ps
`default_nettype none
module ecu_model
  import framer_pkg::*;
(
  input wire logic pclk,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic rx_valid,
  output can_frame_t rx_frame
);
  logic [2:0] cnt = '0;
  initial
  begin
    tx_ready = 1'b0;
    rx_valid = 1'b0;
    rx_frame = '0;
  end
  // alternates prompt and stalling acceptance
  always @(posedge pclk)
  begin
    cnt <= cnt + 3'h1;
    tx_ready <= cnt[2] | (cnt[1:0] == 2'h3);
  end
  task automatic send_cmd(input logic [1:0] ui, input logic [31:0] code, input logic [3:0] n);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_frame <= {1'b1, 3'h1, CMD_PGN_BASE + 18'(ui), 8'h00, n, 32'h0, code};
    @(posedge pclk);
    rx_valid <= 1'b0;
    rx_frame <= ~rx_frame;
  endtask
endmodule // ecu_model
`default_nettype wire

// file: sim/framer_properties.sv
// checker on the framer's ports: frame layout, frame hold, demand range
// assumes binding to actuator_can_message_framer, single pclk domain
`timescale 1ns/1ps
`default_nettype none
module framer_checker
  import framer_pkg::*;
#(
  parameter int TICK_CYC = MS_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire can_frame_t tx_frame,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic [31:0] demand_pos,
  input wire logic [7:0] source_addr,
  input wire logic [1:0] service_bitrate
);
  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  function automatic logic no_rsv(input logic [63:0] d);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
      ok = ok & (d[2*i +: 2] != 2'b10) & (d[32+2*i +: 2] != 2'b10);
    return ok;
  endfunction
  a_service_rate_fixed: assert property (service_bitrate == 2'b11)
    else $error("service rate wrong");
  a_tx_extended_id: assert property (tx_valid |-> tx_frame.ide && tx_frame.dlc == TX_DLC)
    else $error("tx frame not extended or bad length");
  a_tx_frame_held: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_frame))
    else $error("tx frame dropped or changed before taken");
  a_data_layout: assert property (tx_valid && tx_frame.id[25:8] == DATA_PGN |->
    tx_frame.id[28:26] == DATA_PRIO && tx_frame.data[63:16] == 48'hffffffffffff)
    else $error("data frame layout wrong");
  a_diag_layout: assert property (tx_valid && tx_frame.id[25:8] == DIAG_PGN |->
    tx_frame.id[28:26] == DIAG_PRIO && tx_frame.data[31:16] == 16'hffff)
    else $error("diag frame layout wrong");
  a_diag_codes_legal: assert property (tx_valid && tx_frame.id[25:8] == DIAG_PGN |->
    no_rsv(tx_frame.data))
    else $error("reserved diag code sent");
  a_tx_source_addr: assert property ($rose(tx_valid) |-> tx_frame.id[7:0] == source_addr)
    else $error("tx source address wrong");
  a_demand_clamped: assert property (demand_pos >= DEM_LO && demand_pos <= DEM_HI)
    else $error("demand outside 0 to 100 percent");
endmodule // framer_checker
bind actuator_can_message_framer framer_checker #(.TICK_CYC(TICK_CYC)) chk_i (
  .pclk(pclk), .presetn(presetn), .tx_frame(tx_frame), .tx_valid(tx_valid),
  .tx_ready(tx_ready), .demand_pos(demand_pos), .source_addr(source_addr),
  .service_bitrate(service_bitrate));
`default_nettype wire
